// >>> logic/cir_consts.svh
`ifndef CIR_CONSTS_SVH
`define CIR_CONSTS_SVH

// Internal processor register indexes seen on the register move port.
`define CIR_IDX_HW_INTERRUPT_REQUEST_STATUS   5'h0c
`define CIR_IDX_SOFTWARE_INTERRUPT_REQUEST   5'h0d
`define CIR_IDX_ASYNC_TRAP_REQUEST  5'h0e
`define CIR_IDX_CLR    5'h0f
`define CIR_IDX_HIER   5'h10
`define CIR_IDX_SOFTWARE_INTERRUPT_ENABLE   5'h11
`define CIR_IDX_ASYNC_TRAP_ENABLE  5'h12

// Shared read layout of the request and of the enable registers.
`define CIR_R_AST_HI   32
`define CIR_R_AST_LO   29
`define CIR_R_SW_HI    28
`define CIR_R_SW_LO    14
`define CIR_R_SL       13
`define CIR_R_HWA_HI   12
`define CIR_R_HWA_LO   10
`define CIR_R_PC0      9
`define CIR_R_PC1      8
`define CIR_R_HWB_HI   7
`define CIR_R_HWB_LO   5
`define CIR_R_CR       4
`define CIR_R_ATR      3
`define CIR_R_SWR      2
`define CIR_R_HWR      1

// Write layout of the hardware enable register.
`define CIR_W_SLE      32
`define CIR_W_PC1E     15
`define CIR_W_HW_HI    14
`define CIR_W_HW_LO    9
`define CIR_W_PC0E     8
`define CIR_W_CRE      2

// Write layout of the clear register; a zero in a bit clears it.
`define CIR_C_SL       32
`define CIR_C_PC1      15
`define CIR_C_PC0      8
`define CIR_C_CR       2

// Software level 2 sits at index 1 of the level 15..1 vector.
`define CIR_SW_LOCK    1
`define CIR_MODES      4
`define CIR_ZERO64     64'h0000_0000_0000_0000

`endif

// >>> logic/cir_pkg.sv
package cir_pkg;

  // Processor mode; a lower code is a more privileged mode.
  typedef enum logic [1:0] {
    CIR_KERNEL     = 2'b00,
    CIR_EXECUTIVE  = 2'b01,
    CIR_SUPERVISOR = 2'b10,
    CIR_USER       = 2'b11
  } cir_mode_type;

  // Whole state of the request and enable register set.
  typedef struct packed {
    logic [5:0]   irq;
    cir_mode_type cm;
    logic         privileged_firmware_mode;
    logic         rcv;
    logic         rcv_vld;
    logic [3:0]   ast_req;
    logic [14:0]  sw_req;
    logic         serial_line_request_bit;
    logic         pc0_req;
    logic         pc1_req;
    logic         correctable_read_request_bit;
    logic [3:0]   ast_en;
    logic [14:0]  sw_en;
    logic [5:0]   hw_en;
    logic         serial_line_enable_bit;
    logic         pc0_en;
    logic         pc1_en;
    logic         correctable_read_enable_bit;
    logic [63:0]  rdata;
    logic         rd_vld;
    logic         int_req;
  } cir_state_type;

endpackage : cir_pkg

// >>> logic/cir_regs.sv
`timescale 1ns/1ps
`include "cir_consts.svh"
// Summary of operation
// RULE1: Four trap request bits, one per processor mode, each posts a trap.
// RULE2: Fifteen software request bits for levels 15 to 1 post requests.
// RULE3: One readable bit shows a posted serial line request.
// RULE4: The six external request inputs show live in the hardware field.
// RULE5: Counter zero and counter one requests have separate read bits.
// RULE6: Correctable read request sets on error, clears only via clear reg.
// RULE7: Trap summary needs request, enable and mode at least as privileged.
// RULE8: Software summary set when any software request meets its enable.
// RULE9: Hardware summary set when any hardware request meets its enable.
// RULE10: No interrupt is taken while in privileged firmware mode.
// RULE11: Software and trap request reads return all requests and summaries.
// RULE12: A software level interrupts only with request and enable both set.
// RULE13: Trap interrupts happen only while software enable level 2 is set.
// RULE14: Enables map one-to-one; every enable read returns all enables.
// RULE15: Serial enable written at bit 32, read at bit 13.
// RULE16: Trap enable bits 0..3 are kernel, executive, supervisor, user.
// RULE17: Fifteen software enable bits enable the matching levels.
// RULE18: Counter one enable written at bit 15, read at bit 8.
// RULE19: Six hardware enables written at bits 14 to 9.
// RULE20: Counter zero enable written at bit 8, read at bit 9.
// RULE21: Correctable read enable written at bit 2, read at bit 4.
// RULE22: Write-only clear register clears serial, counter, read requests.
// RULE23: Clear bits 32, 15, 8, 2; writing zero clears that source.
// RULE24: Any transition on the serial receive line posts a serial request.
// RULE25: Summaries come from current state, consistent with the fields read.
module cir_regs (
  // Clock and reset.
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // Internal processor register move port.
  input  wire logic               RD,
  input  wire logic               WR,
  input  wire logic [4:0]         IDX,
  input  wire logic [63:0]        WDATA,
  output logic      [63:0]        RDATA,
  output logic                    RD_VALID,
  // Interrupt sources.
  input  wire logic [5:0]         IRQ,
  input  wire logic               RCV,
  input  wire logic               PC0_EVT,
  input  wire logic               PC1_EVT,
  input  wire logic               CRD_EVT,
  // Processor state.
  input  wire cir_pkg::cir_mode_type MODE,
  input  wire logic               PAL_MODE,
  // Request to take an interrupt.
  output logic                    INT_REQ
);
  import cir_pkg::*;

  cir_state_type state_ff;
  cir_state_type nxt_state;

  // Trap summary: a mode's trap counts when the current mode is at least
  // as privileged, and the whole field is locked out by software level 2.
  function automatic logic cir_atr(input cir_state_type s);
    logic hit;
    hit = 1'b0;
    for (int m = 0; m < `CIR_MODES; m++) begin
      if (s.ast_req[m] && s.ast_en[m] && (s.cm <= 2'(m))) begin // RULE7
        hit = 1'b1;
      end
    end
    return hit && s.sw_en[`CIR_SW_LOCK]; // RULE13
  endfunction : cir_atr

  // Software summary: one-to-one pairing of level request and enable.
  function automatic logic cir_swr(input cir_state_type s);
    return |(s.sw_req & s.sw_en); // RULE8 RULE12
  endfunction : cir_swr

  // Hardware summary covers every source enabled in the hardware register.
  // Serial, counter and correctable read sources share this summary path.
  function automatic logic cir_hwr(input cir_state_type s);
    return (|(s.irq & s.hw_en)) // RULE9
           | (s.serial_line_request_bit & s.serial_line_enable_bit) | (s.pc0_req & s.pc0_en)
           | (s.pc1_req & s.pc1_en) | (s.correctable_read_request_bit & s.correctable_read_enable_bit);
  endfunction : cir_hwr

  // Combined request word with summaries built from the same state, so a
  // read never shows a summary that disagrees with its own fields.
  function automatic logic [63:0] cir_req_word(input cir_state_type s);
    logic [63:0] w;
    w = `CIR_ZERO64;
    w[`CIR_R_AST_HI:`CIR_R_AST_LO] = s.ast_req;  // RULE1
    w[`CIR_R_SW_HI:`CIR_R_SW_LO]   = s.sw_req;   // RULE2
    w[`CIR_R_SL]                   = s.serial_line_request_bit;      // RULE3
    w[`CIR_R_HWA_HI:`CIR_R_HWA_LO] = s.irq[2:0]; // RULE4
    w[`CIR_R_HWB_HI:`CIR_R_HWB_LO] = s.irq[5:3]; // RULE4
    w[`CIR_R_PC0]                  = s.pc0_req;  // RULE5
    w[`CIR_R_PC1]                  = s.pc1_req;  // RULE5
    w[`CIR_R_CR]                   = s.correctable_read_request_bit;      // RULE6
    w[`CIR_R_ATR]                  = cir_atr(s); // RULE25
    w[`CIR_R_SWR]                  = cir_swr(s); // RULE25
    w[`CIR_R_HWR]                  = cir_hwr(s); // RULE25
    return w;
  endfunction : cir_req_word

  // Combined enable word in the same layout as the request word.
  function automatic logic [63:0] cir_en_word(input cir_state_type s);
    logic [63:0] w;
    w = `CIR_ZERO64;
    w[`CIR_R_AST_HI:`CIR_R_AST_LO] = s.ast_en;     // RULE14
    w[`CIR_R_SW_HI:`CIR_R_SW_LO]   = s.sw_en;      // RULE14
    w[`CIR_R_SL]                   = s.serial_line_enable_bit;        // RULE15
    w[`CIR_R_HWA_HI:`CIR_R_HWA_LO] = s.hw_en[2:0]; // RULE14
    w[`CIR_R_HWB_HI:`CIR_R_HWB_LO] = s.hw_en[5:3]; // RULE14
    w[`CIR_R_PC0]                  = s.pc0_en;     // RULE20
    w[`CIR_R_PC1]                  = s.pc1_en;     // RULE18
    w[`CIR_R_CR]                   = s.correctable_read_enable_bit;        // RULE21
    return w;
  endfunction : cir_en_word

  // Read decode; the clear register and unmapped indexes read as zero.
  // Reading the clear register is harmless, since it holds no state.
  function automatic logic [63:0] cir_read(input cir_state_type s,
                                           input logic [4:0]    idx);
    logic [63:0] w;
    w = `CIR_ZERO64;
    case (idx)
      `CIR_IDX_HW_INTERRUPT_REQUEST_STATUS,
      `CIR_IDX_SOFTWARE_INTERRUPT_REQUEST,
      `CIR_IDX_ASYNC_TRAP_REQUEST: w = cir_req_word(s); // RULE11
      `CIR_IDX_HIER,
      `CIR_IDX_SOFTWARE_INTERRUPT_ENABLE,
      `CIR_IDX_ASYNC_TRAP_ENABLE: w = cir_en_word(s);  // RULE14
      `CIR_IDX_CLR:   w = `CIR_ZERO64;     // RULE22
      default:        w = `CIR_ZERO64;
    endcase
    return w;
  endfunction : cir_read

  // Next state. Every hardware set outranks a clear in the same cycle, so
  // an event that lands on a clear write is never lost.
  always_comb begin
    logic rx_edge;
    logic clr_wr;
    rx_edge = 1'b0;
    clr_wr  = 1'b0;
    nxt_state = state_ff;

    // Sample the live inputs; the external lines are synchronous already.
    nxt_state.irq     = IRQ;   // RULE4
    nxt_state.cm      = MODE;
    nxt_state.privileged_firmware_mode     = PAL_MODE;
    nxt_state.rcv     = RCV;
    nxt_state.rcv_vld = 1'b1;

    // The first sample after reset has no history, so it cannot be an edge.
    rx_edge = state_ff.rcv_vld && (RCV != state_ff.rcv); // RULE24
    clr_wr  = WR && (IDX == `CIR_IDX_CLR);

    // Sticky requests with clear-by-zero writes. Only a write to the clear
    // index arms the clear, so ordinary writes whose data holds zeros at
    // those positions never drop a pending request.
    nxt_state.serial_line_request_bit = rx_edge | (state_ff.serial_line_request_bit // RULE24
                    & ~(clr_wr & ~WDATA[`CIR_C_SL])); // RULE23
    nxt_state.pc0_req = PC0_EVT | (state_ff.pc0_req
                        & ~(clr_wr & ~WDATA[`CIR_C_PC0])); // RULE22
    nxt_state.pc1_req = PC1_EVT | (state_ff.pc1_req
                        & ~(clr_wr & ~WDATA[`CIR_C_PC1])); // RULE22
    nxt_state.correctable_read_request_bit = CRD_EVT | (state_ff.correctable_read_request_bit // RULE6
                    & ~(clr_wr & ~WDATA[`CIR_C_CR])); // RULE23

    // Software writable request and enable registers.
    if (WR) begin
      case (IDX)
        `CIR_IDX_SOFTWARE_INTERRUPT_REQUEST: begin
          nxt_state.sw_req = WDATA[`CIR_R_SW_HI:`CIR_R_SW_LO]; // RULE2
        end
        `CIR_IDX_ASYNC_TRAP_REQUEST: begin
          nxt_state.ast_req = WDATA[`CIR_R_AST_HI:`CIR_R_AST_LO]; // RULE1
        end
        `CIR_IDX_HIER: begin
          nxt_state.serial_line_enable_bit    = WDATA[`CIR_W_SLE];  // RULE15
          nxt_state.pc1_en = WDATA[`CIR_W_PC1E]; // RULE18
          nxt_state.hw_en  = WDATA[`CIR_W_HW_HI:`CIR_W_HW_LO]; // RULE19
          nxt_state.pc0_en = WDATA[`CIR_W_PC0E]; // RULE20
          nxt_state.correctable_read_enable_bit    = WDATA[`CIR_W_CRE];  // RULE21
        end
        `CIR_IDX_SOFTWARE_INTERRUPT_ENABLE: begin
          nxt_state.sw_en = WDATA[`CIR_R_SW_HI:`CIR_R_SW_LO]; // RULE17
        end
        `CIR_IDX_ASYNC_TRAP_ENABLE: begin
          nxt_state.ast_en = WDATA[`CIR_R_AST_HI:`CIR_R_AST_LO]; // RULE16
        end
        default: begin
          nxt_state.rd_vld = state_ff.rd_vld;
        end
      endcase
    end

    // Reads see the state before this cycle's updates and hold the word
    // until the next read, so a slow consumer still finds it.
    nxt_state.rd_vld = RD;
    if (RD) begin
      nxt_state.rdata = cir_read(state_ff, IDX); // RULE11
    end

    // Firmware mode masks taking any interrupt; summaries still read true.
    // The request lags the summaries by one edge, as a read answer does, so
    // the line matches the summaries of the read word presented with it.
    nxt_state.int_req = ~state_ff.privileged_firmware_mode // RULE10
                        & (cir_atr(state_ff) | cir_swr(state_ff)
                           | cir_hwr(state_ff));
  end

  // State register; reset leaves every request and enable clear.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  // No logic sits between the flops and the pins, so output timing is clean.
  assign RDATA    = state_ff.rdata;
  assign RD_VALID = state_ff.rd_vld;
  assign INT_REQ  = state_ff.int_req;

  // Checks of the register behaviour. Reads are answered one edge late, so
  // read checks compare against the state seen at the strobe edge. Reset
  // disables every check, since the whole state is forced clear then.
  default clocking cir_cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  chk_pal_blocks_int: assert property ( // RULE10
    state_ff.privileged_firmware_mode |=> !INT_REQ)
    else $error("interrupt raised in firmware mode");

  chk_serial_edge_posts: assert property ( // RULE24
    (state_ff.rcv_vld && (RCV != state_ff.rcv))
      |=> state_ff.serial_line_request_bit)
    else $error("serial transition did not post a request");

  chk_crr_sticky: assert property ( // RULE6
    (state_ff.correctable_read_request_bit && !(WR && IDX == `CIR_IDX_CLR && !WDATA[`CIR_C_CR]))
      |=> state_ff.correctable_read_request_bit)
    else $error("correctable read request lost without clear");

  chk_serial_clear_zero: assert property ( // RULE23
    (WR && IDX == `CIR_IDX_CLR && !WDATA[`CIR_C_SL]
      && !(state_ff.rcv_vld && (RCV != state_ff.rcv)))
      |=> !state_ff.serial_line_request_bit)
    else $error("serial request not cleared by zero write");

  chk_clear_reads_zero: assert property ( // RULE22
    (RD && IDX == `CIR_IDX_CLR) |=> (RD_VALID && RDATA == `CIR_ZERO64))
    else $error("clear register read returned state");

  chk_hw_field_live: assert property ( // RULE4
    (RD && IDX == `CIR_IDX_HW_INTERRUPT_REQUEST_STATUS)
      |=> (RDATA[`CIR_R_HWB_HI:`CIR_R_HWB_LO] == $past(IRQ[5:3], 2)))
    else $error("hardware field does not follow request lines");

  chk_sw_write_lands: assert property ( // RULE2
    (WR && IDX == `CIR_IDX_SOFTWARE_INTERRUPT_REQUEST) |=>
      state_ff.sw_req == $past(WDATA[`CIR_R_SW_HI:`CIR_R_SW_LO]))
    else $error("software request write not stored");

  chk_trap_lockout: assert property ( // RULE13
    (RD && !state_ff.sw_en[`CIR_SW_LOCK]) |=> !RDATA[`CIR_R_ATR])
    else $error("trap summary set while level 2 disabled");

  chk_enable_layout: assert property ( // RULE15
    (WR && IDX == `CIR_IDX_HIER) ##1 !WR
      ##1 (RD && IDX == `CIR_IDX_SOFTWARE_INTERRUPT_ENABLE && !WR)
      |=> (RDATA[`CIR_R_SL] == $past(WDATA[`CIR_W_SLE], 3)
           && RDATA[`CIR_R_PC1] == $past(WDATA[`CIR_W_PC1E], 3)
           && RDATA[`CIR_R_PC0] == $past(WDATA[`CIR_W_PC0E], 3)))
    else $error("enable write and read positions disagree");

  chk_sw_summary_read: assert property ( // RULE8
    (RD && IDX == `CIR_IDX_ASYNC_TRAP_REQUEST && |(state_ff.sw_req & state_ff.sw_en))
      |=> RDATA[`CIR_R_SWR])
    else $error("software summary missing on read");

  // Write landing checks: trap request and the trap, software and hardware enables hold what was written.
  chk_ast_write_lands: assert property ( // RULE1
    (WR && IDX == `CIR_IDX_ASYNC_TRAP_REQUEST) |=>
      state_ff.ast_req == $past(WDATA[`CIR_R_AST_HI:`CIR_R_AST_LO]))
    else $error("trap request write not stored");

  chk_trap_en_write: assert property ( // RULE16
    (WR && IDX == `CIR_IDX_ASYNC_TRAP_ENABLE) |=>
      state_ff.ast_en == $past(WDATA[`CIR_R_AST_HI:`CIR_R_AST_LO]))
    else $error("trap enable write not stored");

  chk_sw_en_write: assert property ( // RULE17
    (WR && IDX == `CIR_IDX_SOFTWARE_INTERRUPT_ENABLE) |=>
      state_ff.sw_en == $past(WDATA[`CIR_R_SW_HI:`CIR_R_SW_LO]))
    else $error("software enable write not stored");

  chk_hw_en_write: assert property ( // RULE19
    (WR && IDX == `CIR_IDX_HIER) |=>
      (state_ff.hw_en == $past(WDATA[`CIR_W_HW_HI:`CIR_W_HW_LO])
       && state_ff.correctable_read_enable_bit == $past(WDATA[`CIR_W_CRE])))
    else $error("hardware enable write not stored");

  // Read layout checks: each word is built from the state one edge back.
  chk_serial_read_bit: assert property ( // RULE3
    (RD && IDX == `CIR_IDX_SOFTWARE_INTERRUPT_REQUEST)
      |=> RDATA[`CIR_R_SL] == $past(state_ff.serial_line_request_bit))
    else $error("serial request bit misplaced in read");

  chk_counter_read_bits: assert property ( // RULE5
    (RD && IDX == `CIR_IDX_HW_INTERRUPT_REQUEST_STATUS)
      |=> (RDATA[`CIR_R_PC0] == $past(state_ff.pc0_req)
           && RDATA[`CIR_R_PC1] == $past(state_ff.pc1_req)))
    else $error("counter request bits misplaced in read");

  chk_enable_read_same: assert property ( // RULE14
    (RD && (IDX == `CIR_IDX_HIER || IDX == `CIR_IDX_SOFTWARE_INTERRUPT_ENABLE
            || IDX == `CIR_IDX_ASYNC_TRAP_ENABLE))
      |=> (RDATA[`CIR_R_SW_HI:`CIR_R_SW_LO] == $past(state_ff.sw_en)
           && RDATA[`CIR_R_AST_HI:`CIR_R_AST_LO] == $past(state_ff.ast_en)
           && RDATA[`CIR_R_ATR:`CIR_R_HWR] == 3'h0))
    else $error("enable read is not the full enable set");

  // Summary checks; a user request qualifies in every processor mode.
  chk_trap_user_any: assert property ( // RULE7
    (RD && IDX == `CIR_IDX_ASYNC_TRAP_REQUEST && state_ff.sw_en[`CIR_SW_LOCK]
     && state_ff.ast_req[CIR_USER] && state_ff.ast_en[CIR_USER])
      |=> RDATA[`CIR_R_ATR])
    else $error("user trap request missing from summary");

  chk_trap_mode_low: assert property ( // RULE7
    (RD && IDX == `CIR_IDX_ASYNC_TRAP_REQUEST && state_ff.cm == CIR_SUPERVISOR
     && !state_ff.ast_req[CIR_SUPERVISOR] && !state_ff.ast_req[CIR_USER])
      |=> !RDATA[`CIR_R_ATR])
    else $error("trap summary set for a more privileged request");

  chk_sw_pairing: assert property ( // RULE12
    (RD && IDX == `CIR_IDX_ASYNC_TRAP_REQUEST && !(|(state_ff.sw_req & state_ff.sw_en)))
      |=> !RDATA[`CIR_R_SWR])
    else $error("software summary set without a matched level");

  chk_hw_summary: assert property ( // RULE9
    (RD && IDX == `CIR_IDX_HW_INTERRUPT_REQUEST_STATUS && |(state_ff.irq & state_ff.hw_en))
      |=> RDATA[`CIR_R_HWR])
    else $error("hardware summary absent on read");

  chk_summary_quiet: assert property ( // RULE25
    (RD && IDX == `CIR_IDX_HW_INTERRUPT_REQUEST_STATUS && state_ff.irq == '0 && !state_ff.serial_line_request_bit
     && !state_ff.pc0_req && !state_ff.pc1_req && !state_ff.correctable_read_request_bit)
      |=> !RDATA[`CIR_R_HWR])
    else $error("hardware summary set with no request shown");

  // Source checks; an event always wins over a clear in the same cycle.
  chk_crd_event_sets: assert property ( // RULE6
    CRD_EVT |=> state_ff.correctable_read_request_bit)
    else $error("correctable read event lost");

  chk_pc1_clear_zero: assert property ( // RULE22
    (WR && IDX == `CIR_IDX_CLR && !WDATA[`CIR_C_PC1] && !PC1_EVT)
      |=> !state_ff.pc1_req)
    else $error("counter one request not cleared by zero write");

  chk_pc0_int_taken: assert property ( // RULE20
    (!state_ff.privileged_firmware_mode && state_ff.pc0_req && state_ff.pc0_en) |=> INT_REQ)
    else $error("enabled counter zero request not raised");

  cov_serial_edge: cover property (
    (state_ff.rcv_vld && (RCV != state_ff.rcv)) ##1 state_ff.serial_line_request_bit);
  cov_trap_summary: cover property (RD ##1 RDATA[`CIR_R_ATR]);
  cov_set_on_clear: cover property (
    CRD_EVT && WR && IDX == `CIR_IDX_CLR && !WDATA[`CIR_C_CR]);
  cov_int_taken: cover property (!INT_REQ ##1 INT_REQ);
  cov_firmware_hold: cover property (state_ff.privileged_firmware_mode && cir_hwr(state_ff));

endmodule : cir_regs

// >>> test/cir_irq_src_model.sv
`timescale 1ns/1ps
// Stands in for the system logic that drives the six external request lines.
module cir_irq_src_model (
  // Clock and reset.
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Level asked for by the bench.
  input  wire logic [5:0] LEVEL,
  // Request lines towards the block.
  output logic      [5:0] IRQ
);
  // Lines change only just after an edge, as real synchronous logic would.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 6'h00;
    end else begin
      IRQ <= LEVEL;
    end
  end
endmodule : cir_irq_src_model

// >>> test/cpu_interrupt_request_enable_regs_tb_top.sv
`timescale 1ns/1ps
`include "cir_consts.svh"
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t %s", $time, m); end end
module cpu_interrupt_request_enable_regs_tb_top;
  import cir_pkg::*;
  logic             clk, rst_n, rd, wr, pc0_evt, pc1_evt, crd_evt, rcv;
  logic             pal_mode, rd_valid, int_req;
  logic [4:0]       idx;
  logic [5:0]       irq, irq_level;
  logic [63:0]      wdata, rdata, got;
  cir_mode_type     mode;
  int               fails, num_checks, cycles;

  cir_irq_src_model u_src (.CLK(clk), .RST_N(rst_n), .LEVEL(irq_level),
    .IRQ(irq));
  cir_regs u_dut (.CLK(clk), .RST_N(rst_n), .RD(rd), .WR(wr), .IDX(idx),
    .WDATA(wdata), .RDATA(rdata), .RD_VALID(rd_valid), .IRQ(irq),
    .RCV(rcv), .PC0_EVT(pc0_evt), .PC1_EVT(pc1_evt), .CRD_EVT(crd_evt),
    .MODE(mode), .PAL_MODE(pal_mode), .INT_REQ(int_req));

  // Clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // A hang is cut short well past the 135 or so cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Inputs always move 1 ns after the edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Each transfer ends with a quiet edge, so a following call never
  // drives the same strobe twice in one time step.
  task automatic reg_wr(input logic [4:0] i, input logic [63:0] d);
    wr = 1'b1;
    idx = i;
    wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : reg_wr

  // The answer is registered, so it is taken at the edge after the strobe.
  task automatic reg_rd(input logic [4:0] i, output logic [63:0] d);
    rd = 1'b1;
    idx = i;
    tick(1);
    rd = 1'b0;
    `CHK(rd_valid, 1'b1, "read strobe not answered")
    d = rdata;
    tick(1);
  endtask : reg_rd

  task automatic rd_chk(input logic [4:0] i, input logic [63:0] e);
    reg_rd(i, got);
    `CHK(got, e, "read word differs")
  endtask : rd_chk

  task automatic pulse(input int which);
    pc0_evt = (which == 0);
    pc1_evt = (which == 1);
    crd_evt = (which == 2);
    tick(1);
    {pc0_evt, pc1_evt, crd_evt} = 3'b000;
    tick(1);
  endtask : pulse

  task automatic test_reset();
    for (int i = 12; i <= 18; i++) rd_chk(5'(i), `CIR_ZERO64);
    rd_chk(5'h1f, `CIR_ZERO64);
    `CHK(rd_valid, 1'b0, "valid held too long")
  endtask : test_reset

  task automatic test_soft();
    reg_wr(`CIR_IDX_SOFTWARE_INTERRUPT_REQUEST, 64'h1000_4000);
    reg_wr(`CIR_IDX_SOFTWARE_INTERRUPT_ENABLE, 64'h0000_4000);
    rd_chk(`CIR_IDX_SOFTWARE_INTERRUPT_REQUEST, 64'h1000_4004);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h1000_4004);
    rd_chk(`CIR_IDX_ASYNC_TRAP_REQUEST, 64'h1000_4004);
    rd_chk(`CIR_IDX_HIER, 64'h0000_4000);
    reg_wr(`CIR_IDX_SOFTWARE_INTERRUPT_ENABLE, 64'h0010_0000);
    rd_chk(`CIR_IDX_ASYNC_TRAP_REQUEST, 64'h1000_4000);
    rd_chk(`CIR_IDX_SOFTWARE_INTERRUPT_ENABLE, 64'h0010_0000);
    reg_wr(`CIR_IDX_SOFTWARE_INTERRUPT_REQUEST, `CIR_ZERO64);
  endtask : test_soft

  // Supervisor mode: only supervisor and user trap requests qualify.
  task automatic test_trap();
    logic [63:0] exp_w;
    mode = CIR_SUPERVISOR;
    reg_wr(`CIR_IDX_ASYNC_TRAP_ENABLE, 64'h1_e000_0000);
    reg_wr(`CIR_IDX_SOFTWARE_INTERRUPT_ENABLE, 64'h0000_8000);
    rd_chk(`CIR_IDX_ASYNC_TRAP_ENABLE, 64'h1_e000_8000);
    for (int r = 0; r < 4; r++) begin
      reg_wr(`CIR_IDX_ASYNC_TRAP_REQUEST, 64'h1 << (29 + r));
      exp_w = (64'h1 << (29 + r)) | ((r >= 2) ? 64'h8 : 64'h0);
      rd_chk(`CIR_IDX_ASYNC_TRAP_REQUEST, exp_w);
    end
    reg_wr(`CIR_IDX_SOFTWARE_INTERRUPT_ENABLE, `CIR_ZERO64);
    rd_chk(`CIR_IDX_ASYNC_TRAP_REQUEST, 64'h1_0000_0000);
    reg_wr(`CIR_IDX_ASYNC_TRAP_REQUEST, `CIR_ZERO64);
    reg_wr(`CIR_IDX_ASYNC_TRAP_ENABLE, `CIR_ZERO64);
  endtask : test_trap

  task automatic test_hw();
    irq_level = 6'h2a;
    tick(3);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h08a0);
    reg_wr(`CIR_IDX_HIER, 64'h0200);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h08a0);
    reg_wr(`CIR_IDX_HIER, 64'h1000);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h08a2);
    rd_chk(`CIR_IDX_HIER, 64'h0020);
    pulse(0);
    pulse(1);
    pulse(2);
    rcv = 1'b1;
    tick(3);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h2bb2);
    reg_wr(`CIR_IDX_HIER, 64'h1_0000_8104);
    rd_chk(`CIR_IDX_SOFTWARE_INTERRUPT_ENABLE, 64'h2310);
    reg_wr(`CIR_IDX_CLR, ~64'h1_0000_0100);
    rd_chk(`CIR_IDX_CLR, `CIR_ZERO64);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h09b2);
    irq_level = 6'h00;
    reg_wr(`CIR_IDX_CLR, `CIR_ZERO64);
    tick(2);
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, `CIR_ZERO64);
  endtask : test_hw

  // Firmware mode holds back the request even though the summary shows.
  task automatic test_pal();
    reg_wr(`CIR_IDX_HIER, 64'h0100);
    pal_mode = 1'b1;
    pulse(0);
    tick(3);
    `CHK(int_req, 1'b0, "request taken in firmware mode")
    rd_chk(`CIR_IDX_HW_INTERRUPT_REQUEST_STATUS, 64'h0202);
    pal_mode = 1'b0;
    tick(3);
    `CHK(int_req, 1'b1, "request missing")
    reg_wr(`CIR_IDX_CLR, `CIR_ZERO64);
    tick(3);
    `CHK(int_req, 1'b0, "request not withdrawn")
  endtask : test_pal

  initial begin
    {rst_n, rd, wr, pc0_evt, pc1_evt, crd_evt, rcv, pal_mode} = 8'h00;
    idx = 5'h00;
    wdata = `CIR_ZERO64;
    irq_level = 6'h00;
    mode = CIR_KERNEL;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    tick(10);
    rst_n = 1'b1;
    test_reset();
    test_soft();
    test_trap();
    test_hw();
    test_pal();
    complete_run();
  end
endmodule : cpu_interrupt_request_enable_regs_tb_top
